/* shared/tped_regs.vh */
// Register map, field layout, reset values and timing counts of the thermopile event detector
`ifndef TPED_REGS_VH
`define TPED_REGS_VH

// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define TPED_ADDR_WEIGHTS 12'h000
`define TPED_ADDR_PRES_THR 12'h004
`define TPED_ADDR_MOT_THR 12'h008
`define TPED_ADDR_SHOCK_THR 12'h00c
`define TPED_ADDR_INT_MASK 12'h010
`define TPED_ADDR_CONFIG 12'h014
`define TPED_ADDR_LIMIT_THR 12'h018
`define TPED_ADDR_CHIP_STATUS 12'h01c
`define TPED_ADDR_INT_STATUS 12'h020
`define TPED_ADDR_PRES_DIFF 12'h024
`define TPED_ADDR_MOT_DIFF 12'h028
`define TPED_ADDR_SHOCK_DIFF 12'h02c

// -----------------------------------------------------------------
// Fields
// -----------------------------------------------------------------
`define TPED_CFG_CYCLE_LSB 0
`define TPED_CFG_SRC_LSB 2
`define TPED_CFG_DIR_BIT 4
`define TPED_FLAG_TIMER 0
`define TPED_FLAG_SHOCK 1
`define TPED_FLAG_MOTION 2
`define TPED_FLAG_PRESENCE 3
`define TPED_FLAG_LIMIT 4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define TPED_RST_WEIGHTS 12'h8cb
`define TPED_RST_PRES_THR 8'h32
`define TPED_RST_MOT_THR 8'h0a
`define TPED_RST_SHOCK_THR 8'h0a
`define TPED_RST_INT_MASK 5'h10
`define TPED_RST_CONFIG 5'h19
`define TPED_RST_LIMIT_THR 16'hffff
`define TPED_RST_STATUS 5'h10

// -----------------------------------------------------------------
// Hysteresis and timing
// -----------------------------------------------------------------
`define TPED_HYST_MIN 5
`define TPED_HYST_LIMIT 64
`define TPED_SAMPLE_MS 30
`define TPED_CYCLE0_MS 30
`define TPED_CYCLE1_MS 60
`define TPED_CYCLE2_MS 120
`define TPED_CYCLE3_MS 140
`define TPED_MOTION_DEPTH 5

`endif

/* tb/tb_thermopile_event_detector.sv */
// Self-checking bench for the thermopile event detector
`timescale 1ns/100ps
`include "tped_regs.vh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %0t got %h expected %h", $time, got, exp); end end
module tb_thermopile_event_detector;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic sample_valid = 1'h0;
    logic [16:0] raw_object_sample = 17'h0;
    logic [15:0] raw_ambient_sample = 16'h0;
    wire psel, penable, pwrite, pready, pslverr, int_out;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int m_thr2, base, r;
    logic m_flag, m_pend, m_en, m_dir;
    int obj_q[$];
    logic [31:0] rst_val [8] = '{32'(`TPED_RST_WEIGHTS), 32'(`TPED_RST_PRES_THR),
        32'(`TPED_RST_MOT_THR), 32'(`TPED_RST_SHOCK_THR), 32'(`TPED_RST_INT_MASK),
        32'(`TPED_RST_CONFIG), 32'(`TPED_RST_LIMIT_THR), 32'(`TPED_RST_STATUS)};

    tped_core #(.SAMPLE_CYCLES(1000)) dut (.pclk(pclk), .presetn(presetn),
        .sample_valid(sample_valid), .raw_object_sample(raw_object_sample),
        .raw_ambient_sample(raw_ambient_sample), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .int_out(int_out));
    tped_host h (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            finish_test();
        end
    end

    task finish_test;
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task sample(input int o, input int a);
        sample_valid <= 1'h1;
        raw_object_sample <= o[16:0];
        raw_ambient_sample <= a[15:0];
        @(posedge pclk);
        sample_valid <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask

    // --------------------------------------------------------------
    // Limit model: sets past the threshold, clears only 64 counts beyond
    // --------------------------------------------------------------
    task lim_step(input int o);
        sample(o, 0);
        if (m_dir ? o > m_thr2 : o < m_thr2) begin
            m_pend = m_pend | !m_flag;
            m_flag = 1'h1;
        end else if (m_dir ? o < m_thr2 - 64 : o > m_thr2 + 64) begin
            m_flag = 1'h0;
        end
        `CHK(int_out, m_pend & m_en)
        if (m_pend & m_en) begin
            h.xfer(1'h0, `TPED_ADDR_INT_STATUS, 32'h0);
            `CHK(h.last_rd[`TPED_FLAG_LIMIT], 1'h1)
            m_pend = 1'h0;
            repeat (2) @(posedge pclk);
            `CHK(int_out, 1'h0)
        end
    endtask

    initial begin
        r = $urandom(37089);
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        `CHK(int_out, 1'h1)
        for (int i = 0; i < 8; i++) begin
            h.xfer(1'h0, 12'(4 * i), 32'h0);
            `CHK(h.last_rd, rst_val[i])
        end
        h.xfer(1'h0, 12'h030, 32'h0);
        `CHK({h.last_err, h.last_rd}, 33'h1_0000_0000)
        h.xfer(1'h0, `TPED_ADDR_INT_STATUS, 32'h0);
        `CHK(h.last_rd, 32'(`TPED_RST_STATUS))
        repeat (2) @(posedge pclk);
        `CHK(int_out, 1'h0)
        // --------------------------------------------------------------
        // Limit detector in both directions, masked and unmasked
        // --------------------------------------------------------------
        r = $urandom % 256;
        h.xfer(1'h1, `TPED_ADDR_LIMIT_THR, 32'h1000);
        m_thr2 = 32'h2000;
        base = m_thr2;
        m_flag = 1'h1;
        m_pend = 1'h0;
        m_en = 1'h1;
        m_dir = 1'h1;
        obj_q = '{0, base + 100 + r, base + 100, base - 10, base + 100, base - 100, base + 150};
        foreach (obj_q[i]) lim_step(obj_q[i]);
        h.xfer(1'h1, `TPED_ADDR_CONFIG, 32'h09);
        m_dir = 1'h0;
        obj_q = '{base + 150, base - 100 - r, base - 200};
        foreach (obj_q[i]) lim_step(obj_q[i]);
        h.xfer(1'h1, `TPED_ADDR_INT_MASK, 32'h0);
        m_en = 1'h0;
        obj_q = '{base + 150, base - 100};
        foreach (obj_q[i]) lim_step(obj_q[i]);
        h.xfer(1'h1, `TPED_ADDR_INT_MASK, 32'h10);
        m_en = 1'h1;
        repeat (2) @(posedge pclk);
        `CHK(int_out, 1'h1)
        lim_step(base - 100);
        // --------------------------------------------------------------
        // Presence, motion and shock from a fresh reset, every source and interval
        // --------------------------------------------------------------
        for (int s = 0; s < 4; s++) begin
            presetn <= 1'h0;
            repeat (2) @(posedge pclk);
            presetn <= 1'h1;
            @(posedge pclk);
            `CHK(int_out, 1'h1)
            h.presence_setup();
            h.xfer(1'h1, `TPED_ADDR_CONFIG, 32'(16 + 5 * s));
            // Four quiet samples fill the history of the longest motion interval
            repeat (4) sample(0, 0);
            h.xfer(1'h0, `TPED_ADDR_INT_STATUS, 32'h0);
            repeat (2) @(posedge pclk);
            `CHK(int_out, 1'h0)
            r = 32'h8000 + ($urandom % 32'h8000);
            repeat (2) sample(r, 32'h4000 + r[11:0]);
            `CHK(int_out, 1'h1)
            h.xfer(1'h0, `TPED_ADDR_CHIP_STATUS, 32'h0);
            `CHK(h.last_rd[3:1], 3'h7)
            h.xfer(1'h0, `TPED_ADDR_INT_STATUS, 32'h0);
            `CHK(h.last_rd[`TPED_FLAG_PRESENCE], 1'h1)
        end
        finish_test();
    end
endmodule

bind tped_core tped_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_props (.pclk(pclk),
    .presetn(presetn), .sample_valid(sample_valid), .raw_object_sample(raw_object_sample),
    .raw_ambient_sample(raw_ambient_sample), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_out(int_out));

/* tb/tped_host.sv */
// Host-side bus model that drives register transfers toward the detector
`timescale 1ns/100ps
`include "tped_regs.vh"
module tped_host (
    input wire pclk,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    output logic psel = 1'h0,
    output logic penable = 1'h0,
    output logic pwrite = 1'h0,
    output logic [11:0] paddr = 12'h0,
    output logic [31:0] pwdata = 32'h0
);
    logic [31:0] last_rd;
    logic last_err;
    // Call right after a rising edge; returns one idle edge after the release
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        last_rd = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
    // Start-up for presence work: fast 1011, slow 1000, threshold 50, presence only
    task presence_setup;
        xfer(1'h1, `TPED_ADDR_WEIGHTS, 32'h0000_0a8b);
        xfer(1'h1, `TPED_ADDR_PRES_THR, 32'h0000_0032);
        xfer(1'h1, `TPED_ADDR_INT_MASK, 32'h0000_0008);
    endtask
endmodule

/* tb/tped_props.sv */
// Checker of bus answers and interrupt behaviour at the detector's ports
`timescale 1ns/100ps
`include "tped_regs.vh"
module tped_props #(
    parameter SAMPLE_CYCLES = 600000
) (
    input wire pclk,
    input wire presetn,
    input wire sample_valid,
    input wire [16:0] raw_object_sample,
    input wire [15:0] raw_ambient_sample,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire int_out
);
    wire acc = psel && penable && pready;
    wire wr_acc = acc && pwrite;
    wire rd_int = acc && !pwrite && paddr == `TPED_ADDR_INT_STATUS;
    wire rd_flags = acc && !pwrite && paddr >= `TPED_ADDR_CHIP_STATUS
        && paddr <= `TPED_ADDR_INT_STATUS;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    pready_access_a: assert property (psel && penable |-> pready)
        else $error("pready missing in access phase");
    pready_idle_a: assert property (!(psel && penable) |-> !pready)
        else $error("pready outside access phase");
    unmapped_err_a: assert property (acc && paddr > `TPED_ADDR_SHOCK_DIFF && !pwrite
        |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    mapped_ok_a: assert property (acc && paddr <= `TPED_ADDR_SHOCK_DIFF |-> !pslverr)
        else $error("mapped access refused");
    flag_width_a: assert property (rd_flags |-> prdata[31:5] == 27'h0)
        else $error("status upper bits not zero");
    reset_int_a: assert property ($rose(presetn) |-> int_out)
        else $error("interrupt not active after reset");
    // Interrupt only moves because of a sample, a register write or a status read
    int_rise_a: assert property ($rose(int_out) |-> $past(sample_valid) || $past(wr_acc, 2))
        else $error("interrupt rose without cause");
    int_fall_a: assert property ($fell(int_out) |-> $past(rd_int) || $past(wr_acc, 2))
        else $error("interrupt fell without status read");
    int_clear_a: assert property (rd_int && !sample_valid |-> ##1 !int_out)
        else $error("status read did not clear interrupt");
    cover property (rd_int && int_out);
    cover property ($rose(int_out));
    cover property (acc && pslverr);
endmodule

/* verilog/tped_core.v */
// Event detector: filters, presence/motion/shock/limit flags, APB registers
`timescale 1ns/100ps
// Behaviour
// - Two object low-pass filters, each with its own programmable weight.
// - Presence difference taken from one of four selectable signal pairings.
// - Slow-filtered value frozen when the motion flag becomes set.
// - Presence flag sets when difference exceeds the 8-bit presence threshold.
// - Motion is fast-filter change over a programmable interval, against a threshold.
// - Shock is raw ambient minus filtered ambient, against the shock threshold.
// - Raw object compared to limit threshold; event on crossing in chosen direction.
// - Reading interrupt status clears the pending interrupt; host must read it.
// - Limit detector raises no new interrupt until a fresh crossing.
// - After reset the limit flag is set and the interrupt output active.
// - Presence, motion and shock flags clear only below threshold minus max of 12.5% or 5 counts.
// - Limit comparator uses fixed 64-count hysteresis.
// - New weights and thresholds take effect immediately, no restart.
// - Source codes: raw-slow, fast-slow, raw-frozen, fast-frozen.
// - Motion interval codes select 30, 60, 120 or 120 ms; 140 ms rounds down to 4 samples.
// - Interrupt output is the registered OR of all enabled pending bits.
// - Direction bit one means rising above, zero means falling below.
`include "tped_regs.vh"
module tped_core #(
    parameter SAMPLE_CYCLES = 600000
) (
    input wire pclk,
    input wire presetn,
    input wire sample_valid,
    input wire [16:0] raw_object_sample,
    input wire [15:0] raw_ambient_sample,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg int_out
);
    // -----------------------------------------------------------------
    // Counts sized where they meet narrower fields
    // -----------------------------------------------------------------
    localparam integer HYST_MIN = `TPED_HYST_MIN;
    localparam integer LIMIT_HYST = `TPED_HYST_LIMIT;
    // Motion interval in samples of 30 ms; 140 ms rounds down to 4 samples
    localparam integer LAG0 = `TPED_CYCLE0_MS / `TPED_SAMPLE_MS;
    localparam integer LAG1 = `TPED_CYCLE1_MS / `TPED_SAMPLE_MS;
    localparam integer LAG2 = `TPED_CYCLE2_MS / `TPED_SAMPLE_MS;
    localparam integer LAG3 = `TPED_CYCLE3_MS / `TPED_SAMPLE_MS;
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function [17:0] magnitude;
        input [17:0] d;
        begin
            magnitude = d[17] ? (~d + 18'h00001) : d;
        end
    endfunction

    // Hysteresis-aware flag: set above thr, clear below thr - max(thr/8, 5)
    function hyst_flag;
        input flag;
        input [17:0] mag;
        input [7:0] thr;
        reg [8:0] hy;
        reg [8:0] low;
        begin
            hy = ({1'b0, thr} >> 3) > HYST_MIN[8:0] ? ({1'b0, thr} >> 3) : HYST_MIN[8:0];
            low = ({1'b0, thr} > hy) ? ({1'b0, thr} - hy) : 9'h000;
            if (mag > {10'h000, thr})
                hyst_flag = 1'b1;
            else if (mag < {9'h000, low})
                hyst_flag = 1'b0;
            else
                hyst_flag = flag;
        end
    endfunction

    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    reg [11:0] weights_reg;
    reg [7:0] pres_thr_reg;
    reg [7:0] mot_thr_reg;
    reg [7:0] shock_thr_reg;
    reg [4:0] int_mask_reg;
    reg [4:0] config_reg;
    reg [15:0] limit_thr_reg;
    reg [4:0] status_reg;
    reg [4:0] pending_reg;
    reg [16:0] frozen_slow_object;
    reg [16:0] motion_hist [0:`TPED_MOTION_DEPTH-1];
    reg [2:0] hist_fill;
    reg limit_hit_reg;
    reg [7:0] timer_cnt_reg;
    reg [17:0] presence_difference;
    reg [17:0] motion_difference;
    reg [17:0] ambient_shock_difference;
    integer i;

    wire [16:0] fast_filtered_object;
    wire [16:0] slow_filtered_object;
    wire [16:0] filtered_ambient;
    wire [3:0] fast_filter_weight = weights_reg[3:0];
    wire [3:0] slow_filter_weight = weights_reg[7:4];
    wire [3:0] ambient_filter_weight = weights_reg[11:8];
    wire [1:0] cycle_code = config_reg[`TPED_CFG_CYCLE_LSB +: 2];
    wire [1:0] presence_source_field = config_reg[`TPED_CFG_SRC_LSB +: 2];
    wire limit_direction_bit = config_reg[`TPED_CFG_DIR_BIT];

    // -----------------------------------------------------------------
    // Filters
    // -----------------------------------------------------------------
    tped_lowpass u_fast (
        .pclk(pclk),
        .presetn(presetn),
        .sample_strobe(sample_valid),
        .sample_in(raw_object_sample),
        .weight_code(fast_filter_weight),
        .filtered(fast_filtered_object)
    );
    tped_lowpass u_slow (
        .pclk(pclk),
        .presetn(presetn),
        .sample_strobe(sample_valid),
        .sample_in(raw_object_sample),
        .weight_code(slow_filter_weight),
        .filtered(slow_filtered_object)
    );
    tped_lowpass u_amb (
        .pclk(pclk),
        .presetn(presetn),
        .sample_strobe(sample_valid),
        .sample_in({1'b0, raw_ambient_sample}),
        .weight_code(ambient_filter_weight),
        .filtered(filtered_ambient)
    );

    // -----------------------------------------------------------------
    // Differences
    // -----------------------------------------------------------------
    reg [2:0] lag;
    reg [16:0] pres_a;
    reg [16:0] pres_b;
    always @* begin
        case (cycle_code)
            2'b00: lag = LAG0[2:0];
            2'b01: lag = LAG1[2:0];
            2'b10: lag = LAG2[2:0];
            default: lag = LAG3[2:0];
        endcase
        pres_a = presence_source_field[0] ? fast_filtered_object : raw_object_sample;
        pres_b = presence_source_field[1] ? frozen_slow_object : slow_filtered_object;
        presence_difference = {1'b0, pres_a} - {1'b0, pres_b};
        motion_difference = {1'b0, fast_filtered_object} - {1'b0, motion_hist[lag - 3'd1]};
        ambient_shock_difference = {2'b00, raw_ambient_sample} - {1'b0, filtered_ambient};
    end

    wire [17:0] pres_mag = magnitude(presence_difference);
    wire [17:0] mot_mag = magnitude(motion_difference);
    wire [17:0] shock_mag = magnitude(ambient_shock_difference);
    wire motion_ok = (hist_fill >= lag);

    // Limit comparator, threshold scaled by 2. The 64-count band lies on the re-arm side of the
    // threshold, so an event fires only strictly past the threshold in either direction
    // and the detector re-arms only once the object has left the band.
    wire [17:0] thr2 = {1'b0, limit_thr_reg, 1'b0};
    wire [17:0] obj = {1'b0, raw_object_sample};
    wire [17:0] hyst = LIMIT_HYST[17:0];
    wire over_thr = obj > thr2;
    wire under_thr = obj < thr2;
    wire under_band = obj + hyst < thr2;
    wire over_band = obj > thr2 + hyst;
    reg limit_hit_next;
    always @* begin
        if (limit_direction_bit)
            limit_hit_next = over_thr ? 1'b1 : (under_band ? 1'b0 : limit_hit_reg);
        else
            limit_hit_next = under_thr ? 1'b1 : (over_band ? 1'b0 : limit_hit_reg);
    end
    wire limit_event = limit_hit_next && !limit_hit_reg;

    // -----------------------------------------------------------------
    // Status flags and interrupt
    // -----------------------------------------------------------------
    wire rd_int = psel && penable && !pwrite && paddr == `TPED_ADDR_INT_STATUS;
    wire timer_hit = sample_valid && (timer_cnt_reg == 8'hff);
    reg [4:0] status_next;
    reg [4:0] rise;
    reg [4:0] pending_next;
    always @* begin
        status_next = status_reg;
        if (sample_valid) begin
            status_next[`TPED_FLAG_PRESENCE] = hyst_flag(status_reg[`TPED_FLAG_PRESENCE],
                pres_mag, pres_thr_reg);
            status_next[`TPED_FLAG_MOTION] = motion_ok &&
                hyst_flag(status_reg[`TPED_FLAG_MOTION], mot_mag, mot_thr_reg);
            status_next[`TPED_FLAG_SHOCK] = hyst_flag(status_reg[`TPED_FLAG_SHOCK],
                shock_mag, shock_thr_reg);
            status_next[`TPED_FLAG_LIMIT] = limit_hit_next;
        end
        status_next[`TPED_FLAG_TIMER] = timer_hit;
        rise = status_next & ~status_reg;
        rise[`TPED_FLAG_LIMIT] = sample_valid && limit_event;
        // New events win over a clearing read in the same cycle
        pending_next = (rd_int ? 5'h00 : pending_reg) | rise;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= `TPED_RST_STATUS;
            pending_reg <= `TPED_RST_STATUS;
            int_out <= 1'b1;
            limit_hit_reg <= 1'b1;
            frozen_slow_object <= 17'h00000;
            hist_fill <= 3'h0;
            timer_cnt_reg <= 8'h00;
            for (i = 0; i < `TPED_MOTION_DEPTH; i = i + 1)
                motion_hist[i] <= 17'h00000;
        end else begin
            status_reg <= status_next;
            pending_reg <= pending_next;
            int_out <= |(pending_next & int_mask_reg);
            if (sample_valid) begin
                limit_hit_reg <= limit_hit_next;
                timer_cnt_reg <= timer_cnt_reg + 8'h01;
                for (i = `TPED_MOTION_DEPTH - 1; i > 0; i = i - 1)
                    motion_hist[i] <= motion_hist[i - 1];
                motion_hist[0] <= fast_filtered_object;
                if (hist_fill != `TPED_MOTION_DEPTH)
                    hist_fill <= hist_fill + 3'h1;
                if (rise[`TPED_FLAG_MOTION])
                    frozen_slow_object <= slow_filtered_object;
            end
        end
    end

    // -----------------------------------------------------------------
    // APB slave, zero wait states
    // -----------------------------------------------------------------
    wire apb_wr = psel && penable && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            weights_reg <= `TPED_RST_WEIGHTS;
            pres_thr_reg <= `TPED_RST_PRES_THR;
            mot_thr_reg <= `TPED_RST_MOT_THR;
            shock_thr_reg <= `TPED_RST_SHOCK_THR;
            int_mask_reg <= `TPED_RST_INT_MASK;
            config_reg <= `TPED_RST_CONFIG;
            limit_thr_reg <= `TPED_RST_LIMIT_THR;
        end else if (apb_wr) begin
            case (paddr)
                `TPED_ADDR_WEIGHTS: weights_reg <= pwdata[11:0];
                `TPED_ADDR_PRES_THR: pres_thr_reg <= pwdata[7:0];
                `TPED_ADDR_MOT_THR: mot_thr_reg <= pwdata[7:0];
                `TPED_ADDR_SHOCK_THR: shock_thr_reg <= pwdata[7:0];
                `TPED_ADDR_INT_MASK: int_mask_reg <= pwdata[4:0];
                `TPED_ADDR_CONFIG: config_reg <= pwdata[4:0];
                `TPED_ADDR_LIMIT_THR: limit_thr_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    reg [31:0] rdata;
    reg known;
    always @* begin
        known = 1'b1;
        case (paddr)
            `TPED_ADDR_WEIGHTS: rdata = {20'h00000, weights_reg};
            `TPED_ADDR_PRES_THR: rdata = {24'h000000, pres_thr_reg};
            `TPED_ADDR_MOT_THR: rdata = {24'h000000, mot_thr_reg};
            `TPED_ADDR_SHOCK_THR: rdata = {24'h000000, shock_thr_reg};
            `TPED_ADDR_INT_MASK: rdata = {27'h0000000, int_mask_reg};
            `TPED_ADDR_CONFIG: rdata = {27'h0000000, config_reg};
            `TPED_ADDR_LIMIT_THR: rdata = {16'h0000, limit_thr_reg};
            `TPED_ADDR_CHIP_STATUS: rdata = {27'h0000000, status_reg};
            `TPED_ADDR_INT_STATUS: rdata = {27'h0000000, pending_reg};
            `TPED_ADDR_PRES_DIFF: rdata = {{14{presence_difference[17]}}, presence_difference};
            `TPED_ADDR_MOT_DIFF: rdata = {{14{motion_difference[17]}}, motion_difference};
            `TPED_ADDR_SHOCK_DIFF: rdata = {{14{ambient_shock_difference[17]}},
                ambient_shock_difference};
            default: begin
                rdata = 32'h00000000;
                known = 1'b0;
            end
        endcase
    end

    // Registered answer: setup cycle loads data, access cycle sees pready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata <= (psel && !penable && !pwrite) ? rdata : 32'h00000000;
        end
    end
endmodule

/* verilog/tped_lowpass.v */
// First-order recursive low-pass filter with a selectable shift weight
`timescale 1ns/100ps
module tped_lowpass (
    input wire pclk,
    input wire presetn,
    input wire sample_strobe,
    input wire [16:0] sample_in,
    input wire [3:0] weight_code,
    output wire [16:0] filtered
);
    // -----------------------------------------------------------------
    // Weight as a power-of-two shift
    // -----------------------------------------------------------------
    // Codes 0..5 and 8..13 map onto shifts; weight is 2^-shift, so a new
    // code is used at the very next sample with no restart.
    reg [3:0] shift;
    reg [24:0] acc_reg;
    wire [24:0] in_ext;
    wire signed [25:0] diff;
    wire signed [25:0] step;

    always @* begin
        case (weight_code)
            4'hd: shift = 4'h1;
            4'hc: shift = 4'h2;
            4'hb: shift = 4'h3;
            4'ha: shift = 4'h4;
            4'h9: shift = 4'h5;
            4'h8: shift = 4'h6;
            4'h5: shift = 4'h7;
            4'h4: shift = 4'h8;
            4'h3: shift = 4'h9;
            4'h2: shift = 4'ha;
            4'h1: shift = 4'hb;
            4'h0: shift = 4'hc;
            default: shift = 4'h3;
        endcase
    end

    // Output = in*w + prev*(1-w), kept with 8 fraction bits to avoid drift
    assign in_ext = {sample_in, 8'h00};
    // One spare bit keeps a full-scale input from reading as negative
    assign diff = $signed({1'b0, in_ext}) - $signed({1'b0, acc_reg});
    assign step = diff >>> shift;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 25'h0000000;
        end else if (sample_strobe) begin
            acc_reg <= acc_reg + step[24:0];
        end
    end

    assign filtered = acc_reg[24:8];
endmodule
